// ===== radio_mode_pkg.sv
/*
  Shared definitions for the radio mode controller: mode encodings,
  mode-pin and radio-control carriers, and timing constants.
  Assumes a 200 MHz system clock.
*/
package radio_mode_pkg;

  // Clock period in picoseconds
  localparam int unsigned CLK_PERIOD_PS   = 5000;

  // Time from idle to commit of a new mode, in microseconds
  localparam int unsigned SETTLE_TIME_US  = 1000;
  // Longest time, so rounded down to whole cycles
  localparam int unsigned SETTLE_CYCLES   =
    (SETTLE_TIME_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned SETTLE_COUNT_W  = 18;

  // Cycles that the synchronised pins must hold before a request counts
  localparam int unsigned STABLE_CYCLES   = 16;
  localparam int unsigned STABLE_COUNT_W  = 5;

  // Mode codes, {high pin, low pin}
  typedef enum logic [1:0] {
    MODE_TRANSPARENT = 2'h0,
    MODE_WOR_TX      = 2'h1,
    MODE_WOR_RX      = 2'h2,
    MODE_SLEEP       = 2'h3
  } mode_type;

  localparam mode_type RESET_MODE = MODE_TRANSPARENT;

  typedef struct packed {
    logic high;
    logic low;
  } mode_pins_type;

  typedef struct packed {
    logic rx_on;
    logic tx_on;
    logic preamble_on;
    logic wor_filter_on;
    logic config_on;
  } radio_ctrl_type;

  localparam radio_ctrl_type RESET_RADIO_CTRL = 5'h00;

endpackage : radio_mode_pkg

// ===== mode_sync_filter.sv
/*
  Two-flop synchroniser plus stability filter for a small group of
  level inputs. The filtered value changes only after the synchronised
  value has held for a fixed number of cycles.
  Assumes inputs may change at any time relative to sys_clk.
*/
`timescale 1ns/1ps
module mode_sync_filter #(
  parameter int unsigned WIDTH = 2
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset,
  // Raw and filtered levels
  input  wire logic [WIDTH-1:0] raw,
  input  wire logic [WIDTH-1:0] reset_value,
  output logic      [WIDTH-1:0] stable
);

  logic [WIDTH-1:0]                         meta;
  logic [WIDTH-1:0]                         synced;
  logic [WIDTH-1:0]                         candidate;
  logic [radio_mode_pkg::STABLE_COUNT_W-1:0] hold_count;

  wire differs   = (synced != candidate);
  wire held_long = (hold_count ==
    radio_mode_pkg::STABLE_COUNT_W'(radio_mode_pkg::STABLE_CYCLES - 1));

  // Meta is read by synced alone
  always_ff @(posedge sys_clk) begin
    meta   <= raw;
    synced <= meta;
  end

  // Both bits must settle together, so a skewed pin pair is one request
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      candidate  <= reset_value;
      stable     <= reset_value;
      hold_count <= '0;
    end else if (differs) begin
      candidate  <= synced;
      hold_count <= '0;
    end else if (held_long) begin
      stable     <= candidate;
    end else begin
      hold_count <= hold_count + 1'b1;
    end
  end

endmodule : mode_sync_filter

// ===== radio_mode_controller.sv
/*
  Operating-mode controller: decodes the mode-select pins, defers a mode
  change until pending serial and radio transfers finish, commits it
  after the settle time, and drives the busy indicator and radio enables.
  Assumes the datapath reports its pending work as levels and that the
  parameter store answers a configuration request with config_done.
*/
// Operation
// - Pins decode to four operating modes
// - Sleep: radio off, configuration still accepted
// - Idle change takes effect after settle time
// - Finish pending radio send before switching
// - Finish serial forwarding before switching
// - Commit only while busy indicator high
// - Sleep entered automatically after data drains; here only when the pins select sleep
// - Any change commits after current event
// - Transparent mode sends serial input over radio
// - Transparent mode receives and forwards radio data
// - Wake transmitter mode prepends wake preamble
// - Wake transmitter mode receives like transparent
// - Wake receiver: no transmit, wake packets only
// - Indicator low whenever any busy condition
// - Leaving sleep reconfigures with indicator low
`timescale 1ns/1ps
module radio_mode_controller #(
  parameter int unsigned SETTLE_CYCLES = radio_mode_pkg::SETTLE_CYCLES
) (
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     reset,
  // Mode select pins
  input  wire logic                     mode_select_high,
  input  wire logic                     mode_select_low,
  // Datapath status
  input  wire logic                     uart_rx_pending,
  input  wire logic                     radio_tx_active,
  input  wire logic                     uart_tx_pending,
  // Parameter store handshake
  input  wire logic                     config_done,
  output logic                          config_request,
  // Mode and radio control
  output radio_mode_pkg::mode_type      active_mode,
  output radio_mode_pkg::radio_ctrl_type radio_ctrl,
  output logic                          mode_commit,
  // Busy indicator, low while busy
  output logic                          busy_n
);

  // One-hot: each state test is a single flop, at the cost of width
  typedef enum logic [3:0] {
    ST_RUN    = 4'h1,
    ST_DRAIN  = 4'h2,
    ST_SETTLE = 4'h4,
    ST_CONFIG = 4'h8
  } ctrl_state_type;

  ctrl_state_type                             state;
  ctrl_state_type                             next_state;
  logic [radio_mode_pkg::SETTLE_COUNT_W-1:0]  settle_count;
  logic [1:0]                                 stable_pins;
  radio_mode_pkg::mode_pins_type              pins;
  radio_mode_pkg::mode_pins_type              reset_pins;
  radio_mode_pkg::mode_type                   requested_mode;
  radio_mode_pkg::radio_ctrl_type             next_radio_ctrl;

  assign pins.high  = mode_select_high;
  assign pins.low   = mode_select_low;
  assign reset_pins = radio_mode_pkg::RESET_MODE;

  // Filter latency is small beside the settle time and stops chatter
  mode_sync_filter #(
    .WIDTH       (2)
  ) pin_filter (
    .sys_clk     (sys_clk),
    .reset       (reset),
    .raw         (pins),
    .reset_value (reset_pins),
    .stable      (stable_pins)
  );

  // High pin is the upper bit of the mode code
  assign requested_mode = radio_mode_pkg::mode_type'(stable_pins);

  // Pending work in either direction holds the switch back
  wire data_busy = uart_rx_pending | radio_tx_active | uart_tx_pending;
  wire cfg_busy  = (state == ST_CONFIG);
  wire idle      = ~(data_busy | cfg_busy);

  wire change_wanted = (requested_mode != active_mode);
  wire settle_done   = (settle_count ==
    radio_mode_pkg::SETTLE_COUNT_W'(SETTLE_CYCLES - 1));
  wire leaving_sleep = (active_mode == radio_mode_pkg::MODE_SLEEP);
  wire commit_now    = (state == ST_SETTLE) & change_wanted & idle &
                       settle_done;

  // Indicator falls on the commit edge when sleep is left, so it is
  // never high while a reconfiguration is pending
  wire next_busy_n = idle & (next_state != ST_CONFIG);

  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (change_wanted) begin
          next_state = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        if (!change_wanted) begin
          next_state = ST_RUN;
        end else if (idle) begin
          next_state = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (!change_wanted) begin
          next_state = ST_RUN;
        end else if (!idle) begin
          next_state = ST_DRAIN;
        end else if (settle_done) begin
          next_state = leaving_sleep ? ST_CONFIG : ST_RUN;
        end
      end
      ST_CONFIG: begin
        if (config_done) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_CONFIG;
      end
    endcase
  end

  // Radio enables follow the committed mode only
  always_comb begin
    next_radio_ctrl = radio_mode_pkg::RESET_RADIO_CTRL;
    case (active_mode)
      radio_mode_pkg::MODE_TRANSPARENT: begin
        next_radio_ctrl.tx_on = 1'b1;
        next_radio_ctrl.rx_on = 1'b1;
      end
      radio_mode_pkg::MODE_WOR_TX: begin
        next_radio_ctrl.tx_on       = 1'b1;
        next_radio_ctrl.preamble_on = 1'b1;
        next_radio_ctrl.rx_on       = 1'b1;
      end
      radio_mode_pkg::MODE_WOR_RX: begin
        next_radio_ctrl.rx_on         = 1'b1;
        next_radio_ctrl.wor_filter_on = 1'b1;
      end
      radio_mode_pkg::MODE_SLEEP: begin
        next_radio_ctrl.config_on = 1'b1;
      end
      default: begin
        next_radio_ctrl = radio_mode_pkg::RESET_RADIO_CTRL;
      end
    endcase
  end

  // Reset acts as power-on: a configuration pass runs first, busy low
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= ST_CONFIG;
    end else begin
      state <= next_state;
    end
  end

  // Counter restarts whenever work reappears, so settle time is idle time
  always_ff @(posedge sys_clk) begin
    if (reset || state != ST_SETTLE || !idle) begin
      settle_count <= '0;
    end else if (!settle_done) begin
      settle_count <= settle_count + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      active_mode <= radio_mode_pkg::RESET_MODE;
    end else if (commit_now) begin
      active_mode <= requested_mode;
    end
  end

  // One pulse per switch, so downstream state reloads only once
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mode_commit <= 1'b0;
    end else begin
      mode_commit <= commit_now;
    end
  end

  // Registered so the radio never sees a decode glitch
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      radio_ctrl <= radio_mode_pkg::RESET_RADIO_CTRL;
    end else begin
      radio_ctrl <= next_radio_ctrl;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      busy_n <= 1'b0;
    end else begin
      busy_n <= next_busy_n;
    end
  end

  // Raised with the state change, so the store starts at once
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      config_request <= 1'b0;
    end else begin
      config_request <= (next_state == ST_CONFIG);
    end
  end

endmodule : radio_mode_controller

// ===== radio_mode_controller_sva.sv
/*
  Port checker for the radio mode controller.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module radio_mode_controller_sva #(
  parameter int unsigned SETTLE_CYCLES = radio_mode_pkg::SETTLE_CYCLES
) (
  // Clock, reset and inputs
  input wire logic                           sys_clk,
  input wire logic                           reset,
  input wire logic                           mode_select_high,
  input wire logic                           mode_select_low,
  input wire logic                           uart_rx_pending,
  input wire logic                           radio_tx_active,
  input wire logic                           uart_tx_pending,
  input wire logic                           config_done,
  // Outputs
  input wire logic                           config_request,
  input wire radio_mode_pkg::mode_type       active_mode,
  input wire radio_mode_pkg::radio_ctrl_type radio_ctrl,
  input wire logic                           mode_commit,
  input wire logic                           busy_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [1:0] up;
  logic       any_busy;
  logic       ready;
  assign any_busy = uart_rx_pending | radio_tx_active | uart_tx_pending;
  // Enables lag the mode by one cycle, so skip the commit cycle
  assign ready = (up == 2'h3) && !mode_commit;
  always_ff @(posedge sys_clk) begin
    if (reset)
      up <= 2'h0;
    else if (up != 2'h3)
      up <= up + 2'h1;
  end
  // Cycles the indicator has stood high without a break
  int unsigned idle_run;
  always_ff @(posedge sys_clk) begin
    if (reset || !busy_n)
      idle_run <= '0;
    else if (idle_run < SETTLE_CYCLES)
      idle_run <= idle_run + 1;
  end
  a_settle_time: assert property (
    mode_commit |-> idle_run >= SETTLE_CYCLES - 1)
    else $error("commit before settle time");
  a_commit_one_cycle: assert property (mode_commit |=> !mode_commit)
    else $error("commit pulse too long");
  a_commit_new_mode: assert property (
    mode_commit |-> active_mode != $past(active_mode))
    else $error("commit without mode change");
  a_mode_holds: assert property (!mode_commit |-> $stable(active_mode))
    else $error("mode changed without commit");
  a_commit_when_idle: assert property (mode_commit |-> $past(busy_n))
    else $error("commit while busy");
  a_busy_low: assert property (any_busy |=> !busy_n)
    else $error("busy indicator high while busy");
  a_config_busy: assert property (config_request |-> !busy_n)
    else $error("idle during configuration");
  a_config_holds: assert property (
    config_request && !config_done |=> config_request)
    else $error("configuration request dropped");
  a_sleep_exit: assert property (
    mode_commit && $past(active_mode) == radio_mode_pkg::MODE_SLEEP
    |=> config_request)
    else $error("no reconfiguration after sleep");
  a_tx_enable: assert property (ready |-> radio_ctrl.tx_on ==
    (active_mode inside {radio_mode_pkg::MODE_TRANSPARENT,
                         radio_mode_pkg::MODE_WOR_TX}))
    else $error("transmit enable wrong");
  a_preamble_mode: assert property (ready |->
    radio_ctrl.preamble_on == (active_mode == radio_mode_pkg::MODE_WOR_TX))
    else $error("preamble enable wrong");
  a_rx_enable: assert property (ready |->
    radio_ctrl.rx_on == (active_mode != radio_mode_pkg::MODE_SLEEP))
    else $error("receive enable wrong");
  c_commit: cover property (mode_commit);
  c_config_end: cover property (config_request ##1 !config_request);
  c_idle_again: cover property (!busy_n ##1 busy_n);
endmodule : radio_mode_controller_sva

bind radio_mode_controller radio_mode_controller_sva #(
  .SETTLE_CYCLES(SETTLE_CYCLES)
) radio_mode_controller_sva_i (
  .sys_clk, .reset, .mode_select_high, .mode_select_low,
  .uart_rx_pending, .radio_tx_active, .uart_tx_pending, .config_done,
  .config_request, .active_mode, .radio_ctrl, .mode_commit, .busy_n);

// ===== param_store_model.sv
/*
  Parameter store stand-in: one done pulse a fixed delay after a request.
  Assumes the request stays high until done is seen.
*/
`timescale 1ns/1ps
module param_store_model #(
  parameter int unsigned DELAY = 5
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset,
  // Handshake
  input  wire logic config_request,
  output logic      config_done
);
  logic [3:0] count;
  always_ff @(posedge sys_clk) begin
    if (reset || !config_request)
      count <= 4'h0;
    else if (count != 4'hF)
      count <= count + 4'h1;
  end
  // A pulse, not a level, so a stale done never ends the next request
  assign config_done = (count == DELAY[3:0]);
endmodule : param_store_model

// ===== radio_mode_controller_bench.sv
/*
  Bench: mode walk, deferral by each busy input, sleep exit, restart of
  the settle time.
  Assumes the parameter store model answers configuration.
*/
`timescale 1ns/1ps
module radio_mode_controller_bench;
  logic                           sys_clk = 1'b0;
  logic                           reset = 1'b1;
  logic [1:0]                     pins = 2'h0;
  logic [2:0]                     busy = 3'h0;
  logic                           config_done;
  logic                           config_request;
  logic                           mode_commit;
  logic                           busy_n;
  radio_mode_pkg::mode_type       active_mode;
  radio_mode_pkg::radio_ctrl_type radio_ctrl;
  int                             mismatches = 0;
  int                             n_checks = 0;

  always #2.5 sys_clk = ~sys_clk;

  radio_mode_controller #(.SETTLE_CYCLES(8)) radio_mode_controller_i (
    .sys_clk, .reset, .mode_select_high(pins[1]),
    .mode_select_low(pins[0]), .uart_rx_pending(busy[0]),
    .radio_tx_active(busy[1]), .uart_tx_pending(busy[2]), .config_done,
    .config_request, .active_mode, .radio_ctrl, .mode_commit, .busy_n);
  param_store_model param_store_model_i (
    .sys_clk, .reset, .config_request, .config_done);

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic check(input string what, input logic [7:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  // Enables each mode should show, {rx, tx, preamble, filter, config}
  function automatic logic [7:0] ctrl_for(input logic [1:0] mode);
    case (mode)
      2'h0:    return 8'h18;
      2'h1:    return 8'h1C;
      2'h2:    return 8'h12;
      default: return 8'h01;
    endcase
  endfunction : ctrl_for

  task automatic wait_commit(input int limit, output int waited);
    waited = 0;
    for (int i = 1; i <= limit && waited == 0; i++) begin
      tick(1);
      if (mode_commit === 1'b1)
        waited = i;
    end
  endtask : wait_commit

  // Host waits for the indicator before touching the pins again
  task automatic wait_idle;
    for (int i = 0; i < 30 && busy_n !== 1'b1; i++)
      tick(1);
    check("idle", 4'h1, busy_n);
    tick(4);
  endtask : wait_idle

  task automatic t_switch(input logic [1:0] mode);
    logic [1:0] old = active_mode;
    int         w;
    pins = mode;
    wait_commit(60, w);
    check("delay", 4'h1, w >= 24 && w <= 36);
    check("mode", mode, active_mode);
    if (old == 2'h3) begin
      tick(1);
      check("reconfig", 4'h2, {config_request, busy_n});
    end
    wait_idle();
    check("radio", ctrl_for(mode), radio_ctrl);
    $display("Test switch to mode %0d done", mode);
  endtask : t_switch

  task automatic t_defer(input int idx, input logic [1:0] mode);
    int w;
    busy[idx] = 1'b1;
    pins = mode;
    wait_commit(60, w);
    check("held", 4'h0, w != 0);
    check("busy", 4'h0, busy_n);
    busy[idx] = 1'b0;
    wait_commit(20, w);
    check("late", 4'h1, w >= 9 && w <= 15);
    check("mode", mode, active_mode);
    wait_idle();
    $display("Test deferral by input %0d done", idx);
  endtask : t_defer

  // Work that reappears mid-settle makes the idle wait start over
  task automatic t_restart(input logic [1:0] mode);
    int w;
    pins = mode;
    tick(24);
    busy[1] = 1'b1;
    tick(1);
    busy[1] = 1'b0;
    wait_commit(40, w);
    check("restart", 4'h1, w >= 9 && w <= 15);
    check("mode", mode, active_mode);
    wait_idle();
    $display("Test settle restart done");
  endtask : t_restart

  task automatic summarize;
    $display("Checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  initial begin
    tick(4);
    reset = 1'b0;
    tick(2);
    check("cfg", 4'h1, config_request);
    check("reset busy", 4'h0, busy_n);
    check("reset mode", 4'h0, active_mode);
    wait_idle();
    $display("Test reset done");
    t_switch(2'h1);
    t_switch(2'h2);
    t_switch(2'h3);
    t_switch(2'h0);
    t_defer(1, 2'h1);
    t_defer(2, 2'h2);
    t_defer(0, 2'h3);
    t_switch(2'h0);
    t_restart(2'h1);
    summarize();
  end

  initial begin
    #15000;
    mismatches++;
    summarize();
  end
endmodule : radio_mode_controller_bench
